// ---- verilog/pic_pkg.sv ----
// shared constants of the priority interrupt controller
package pic_pkg;
	// ----------------------------------------------------------------
	// level layout: chain index 0 is the highest priority
	// ----------------------------------------------------------------
	localparam int NUM_LVL = 98;
	localparam int NUM_SPECIAL = 2;
	localparam int NUM_PROG = 96;
	localparam int GRP_SIZE = 12;
	localparam int GRP0_OPT = 10;
	localparam int NUM_SRC = 100;
	localparam int LVL_PWR_FAIL = 0;
	localparam int LVL_STALL = 1;
	localparam int LVL_STD11 = 12;
	localparam int LVL_STD12 = 13;
	localparam int SRC_UNIT11 = 98;
	localparam int SRC_UNIT12 = 99;

	// ----------------------------------------------------------------
	// instruction codes and word fields
	// ----------------------------------------------------------------
	localparam logic [15:0] OP_GRP_ENABLE = 16'h02C6;
	localparam logic [15:0] OP_GRP_DISABLE = 16'hB181;
	localparam int SEL_GRP_LSB = 12;
	localparam int CONN_BIT_CONNECT = 14;
	localparam int CONN_BIT_L11 = 13;
	localparam int CONN_BIT_L12 = 12;

	// ----------------------------------------------------------------
	// vector locations and the wired-in branch word
	// ----------------------------------------------------------------
	localparam logic [15:0] VEC_BASE = 16'h0202;
	localparam logic [15:0] VEC_SPECIAL = 16'h0200;
	localparam logic [15:0] SPB_TEMPLATE = 16'hC000;
	localparam logic [15:0] SPB_ADDR_MASK = 16'h03FF;

	// ----------------------------------------------------------------
	// register byte offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_OPCODE = 8'h04;
	localparam logic [7:0] A_SELECT = 8'h08;
	localparam logic [7:0] A_CONNECT = 8'h0C;
	localparam logic [7:0] A_GROUP = 8'h10;
	localparam logic [7:0] A_ENABLE = 8'h14;
	localparam logic [7:0] A_REQUEST = 8'h18;
	localparam logic [7:0] A_ACTIVE = 8'h1C;
	localparam logic [7:0] A_STATUS = 8'h20;
	localparam logic CTRL_RESET = 1'b0;
	localparam logic [15:0] OPCODE_RESET = 16'h0000;
endpackage

// ---- verilog/pic_prio_enc.sv ----
// unitary-to-binary converter: index of the highest-priority set bit
`timescale 1ns/1ps
module pic_prio_enc (
	input wire logic [pic_pkg::NUM_LVL-1:0] vec_i,
	output logic found_o,
	output logic [6:0] idx_o
);
	// scan from the top index down so the lowest index, the highest priority, wins
	always_comb
	begin
		found_o = 1'b0;
		idx_o = 7'h00;
		for (int i = pic_pkg::NUM_LVL - 1; i >= 0; i--)
		begin
			if (vec_i[i])
			begin
				found_o = 1'b1;
				idx_o = 7'(i);
			end
		end
	end
endmodule // pic_prio_enc

// ---- verilog/pic_ctrl.sv ----
// priority interrupt controller: level chain, vector encoder, Avalon-MM registers
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps

// What this block does
// - ninety-eight levels, ninety-six program enabled
// - groups of twelve, first holds ten optional
// - two special levels always enabled, top priority
// - vectors start octal 1002, ascending downward
// - grant yields store-place-branch indirect through vector
// - interrupt only if enabled, no higher active
// - blocked requests wait; interrupted routines resume later
// - many requests, service strictly by priority
// - panel switch off holds active, enable clear
// - strobe sets or clears selected enable latches
// - source sets request latch only on strobe
// - request needs request, enable, no higher routine
// - grant strobes encoder, branch word onto bus
// - set request latch of an enabled level inhibits all lower levels
// - grant sets active, inhibiting lower; request stays set until reset-active
// - reset-active clears only the highest active level
// - standard levels are group 0 levels 11, 12
// - connect word bit 1 connects levels bits 2,3
// - enable code 1306, disable code 130601
// - selection word: three-bit group, twelve one-hot levels
// - group 000 highest; bit 15 is level 1
// - unselected levels keep their enable state
module pic_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	input wire logic pwr_fail_i,
	input wire logic stall_i,
	input wire logic [pic_pkg::NUM_PROG-1:0] irq_src_i,
	input wire logic [1:0] unit_std_i,
	input wire logic req_strobe_i,
	input wire logic grant_i,
	input wire logic reset_active_i,
	output logic irq_o,
	output logic override_o,
	output logic [15:0] spb_word_o,
	output logic spb_valid_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [pic_pkg::NUM_SRC-1:0] s1;
		logic [pic_pkg::NUM_SRC-1:0] s2;
		logic [pic_pkg::NUM_LVL-1:0] req;
		logic [pic_pkg::NUM_LVL-1:0] act;
		logic [pic_pkg::NUM_PROG-1:0] en;
		logic [1:0] conn;
		logic panel;
		logic [15:0] opcode;
		logic [2:0] grp;
		logic [15:0] store_place_branch;
		logic spb_vld;
		logic ack;
		logic [31:0] rdata;
	} pic_state_t;

	pic_state_t st;
	pic_state_t next_st;

	logic [pic_pkg::NUM_LVL-1:0] src;
	logic [pic_pkg::NUM_LVL-1:0] en_full;
	logic [pic_pkg::NUM_LVL-1:0] blocker;
	logic [pic_pkg::NUM_LVL-1:0] inh;
	logic [pic_pkg::NUM_LVL-1:0] pend;
	logic pend_any;
	logic [6:0] pend_idx;
	logic act_any;
	logic [6:0] act_idx;
	logic [31:0] wd;
	logic [pic_pkg::NUM_PROG-1:0] sel_mask;
	logic bus_done;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [pic_pkg::NUM_LVL-1:0] prefix_or(input logic [pic_pkg::NUM_LVL-1:0] v);
		logic [pic_pkg::NUM_LVL-1:0] r;
		r = '0;
		for (int i = 1; i < pic_pkg::NUM_LVL; i++)
		begin
			r[i] = r[i-1] | v[i-1];
		end
		return r;
	endfunction

	function automatic logic [11:0] grp_slice(input logic [pic_pkg::NUM_PROG-1:0] v, input logic [2:0] g);
		logic [pic_pkg::NUM_PROG-1:0] t;
		t = v >> (pic_pkg::GRP_SIZE * int'(g));
		return t[11:0];
	endfunction

	// special levels sit below the programmable vector block
	function automatic logic [15:0] spb_of(input logic [6:0] idx);
		logic [15:0] a;
		if (idx < 7'(pic_pkg::NUM_SPECIAL))
		begin
			a = pic_pkg::VEC_SPECIAL + {9'h000, idx};
		end
		else
		begin
			a = pic_pkg::VEC_BASE + {9'h000, idx} - 16'(pic_pkg::NUM_SPECIAL);
		end
		return pic_pkg::SPB_TEMPLATE | (a & pic_pkg::SPB_ADDR_MASK);
	endfunction

	// ----------------------------------------------------------------
	// priority chain
	// ----------------------------------------------------------------
	always_comb
	begin
		src = st.s2[pic_pkg::NUM_LVL-1:0];
		// a unit reaches a standard level only while connected
		src[pic_pkg::LVL_STD11] = st.s2[pic_pkg::LVL_STD11] | (st.s2[pic_pkg::SRC_UNIT11] & st.conn[0]);
		src[pic_pkg::LVL_STD12] = st.s2[pic_pkg::LVL_STD12] | (st.s2[pic_pkg::SRC_UNIT12] & st.conn[1]);
	end

	assign en_full = {st.en, 2'b11};
	// only an enabled pending request or an active level holds off lower levels, so a disabled request cannot starve them
	assign blocker = (st.req & en_full) | st.act;
	assign inh = prefix_or(blocker);
	assign pend = st.req & en_full & ~st.act & ~inh;
	assign irq_o = pend_any;
	assign override_o = pend[pic_pkg::LVL_PWR_FAIL] | pend[pic_pkg::LVL_STALL];

	pic_prio_enc u_pend_enc (
		.vec_i(pend),
		.found_o(pend_any),
		.idx_o(pend_idx)
	);

	pic_prio_enc u_act_enc (
		.vec_i(st.act),
		.found_o(act_any),
		.idx_o(act_idx)
	);

	// ----------------------------------------------------------------
	// bus side
	// ----------------------------------------------------------------
	assign wd = writedata_i & {{8{byteenable_i[3]}}, {8{byteenable_i[2]}}, {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
	assign sel_mask = {84'h0, wd[11:0]} << (pic_pkg::GRP_SIZE * int'(wd[14:pic_pkg::SEL_GRP_LSB]));
	assign waitrequest_o = ~st.ack;
	assign bus_done = write_i & st.ack;
	assign readdata_o = st.rdata;
	assign spb_word_o = st.store_place_branch;
	assign spb_valid_o = st.spb_vld;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.s1 = {unit_std_i, irq_src_i, stall_i, pwr_fail_i};
		next_st.s2 = st.s1;
		next_st.ack = (read_i | write_i) & ~st.ack;
		next_st.spb_vld = 1'b0;

		// the highest running routine ends; lower interrupted ones stay active
		if (reset_active_i && act_any)
		begin
			next_st.act[act_idx] = 1'b0;
			next_st.req[act_idx] = 1'b0;
		end

		// new requests are applied after the clear so an arrival is never lost
		if (req_strobe_i)
		begin
			next_st.req = next_st.req | src;
		end

		if (grant_i && pend_any)
		begin
			next_st.act[pend_idx] = 1'b1;
			next_st.store_place_branch = spb_of(pend_idx);
			next_st.spb_vld = 1'b1;
		end

		if (bus_done)
		begin
			case (address_i)
				pic_pkg::A_CTRL:
				begin
					next_st.panel = wd[0];
				end
				pic_pkg::A_OPCODE:
				begin
					next_st.opcode = wd[15:0];
				end
				pic_pkg::A_SELECT:
				begin
					if (st.opcode == pic_pkg::OP_GRP_ENABLE)
					begin
						next_st.en = st.en | sel_mask;
					end
					else if (st.opcode == pic_pkg::OP_GRP_DISABLE)
					begin
						next_st.en = st.en & ~sel_mask;
					end
					else
					begin
						next_st.en = st.en;
					end
				end
				pic_pkg::A_CONNECT:
				begin
					if (wd[pic_pkg::CONN_BIT_L11])
					begin
						next_st.conn[0] = wd[pic_pkg::CONN_BIT_CONNECT];
					end
					if (wd[pic_pkg::CONN_BIT_L12])
					begin
						next_st.conn[1] = wd[pic_pkg::CONN_BIT_CONNECT];
					end
				end
				pic_pkg::A_GROUP:
				begin
					next_st.grp = wd[2:0];
				end
				default:
				begin
					next_st.grp = st.grp;
				end
			endcase
		end

		// panel switch off overrides the active and enable updates above
		if (!st.panel)
		begin
			next_st.act = '0;
			next_st.en = '0;
		end

		if (read_i && !st.ack)
		begin
			case (address_i)
				pic_pkg::A_CTRL: next_st.rdata = {31'h0, st.panel};
				pic_pkg::A_OPCODE: next_st.rdata = {16'h0, st.opcode};
				pic_pkg::A_CONNECT: next_st.rdata = {30'h0, st.conn};
				pic_pkg::A_GROUP: next_st.rdata = {29'h0, st.grp};
				pic_pkg::A_ENABLE: next_st.rdata = {20'h0, grp_slice(st.en, st.grp)};
				pic_pkg::A_REQUEST: next_st.rdata = {20'h0, grp_slice(st.req[pic_pkg::NUM_LVL-1:2], st.grp)};
				pic_pkg::A_ACTIVE: next_st.rdata = {20'h0, grp_slice(st.act[pic_pkg::NUM_LVL-1:2], st.grp)};
				pic_pkg::A_STATUS:
				begin
					next_st.rdata = {12'h0, st.act[1:0], st.req[1:0], pend_any, pend_idx, act_any, act_idx};
				end
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st <= '0;
			st.panel <= pic_pkg::CTRL_RESET;
			st.opcode <= pic_pkg::OPCODE_RESET;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_grant_sets_active;
		(grant_i && pend_any && st.panel) |=> (spb_valid_o && st.act[$past(pend_idx)] && spb_word_o == spb_of($past(pend_idx)));
	endproperty
	a_grant_sets_active: assert property (p_grant_sets_active) else $error("grant did not set active");

	property p_valid_only_on_grant;
		spb_valid_o |-> ($past(grant_i) && $past(pend_any));
	endproperty
	a_valid_only_on_grant: assert property (p_valid_only_on_grant) else $error("branch word without grant");

	property p_connect_keep;
		(bus_done && address_i == pic_pkg::A_CONNECT && !wd[pic_pkg::CONN_BIT_L12]) |=> (st.conn[1] == $past(st.conn[1]));
	endproperty
	a_connect_keep: assert property (p_connect_keep) else $error("unselected standard level changed");

	property p_strobe_sets_req;
		req_strobe_i |=> ((st.req & $past(src)) == $past(src));
	endproperty
	a_strobe_sets_req: assert property (p_strobe_sets_req) else $error("strobe lost a source");

	property p_no_strobe_no_req;
		!req_strobe_i |=> ((st.req & ~$past(st.req)) == '0);
	endproperty
	a_no_strobe_no_req: assert property (p_no_strobe_no_req) else $error("request set without strobe");

	property p_panel_hold;
		!st.panel |=> (st.en == '0 && st.act == '0);
	endproperty
	a_panel_hold: assert property (p_panel_hold) else $error("panel off did not clear");

	property p_single_grant;
		$onehot0(pend);
	endproperty
	a_single_grant: assert property (p_single_grant) else $error("more than one level pending");

	property p_no_higher_block;
		pend_any |-> ((blocker & ((98'(1) << pend_idx) - 98'(1))) == '0);
	endproperty
	a_no_higher_block: assert property (p_no_higher_block) else $error("higher level was bypassed");

	property p_reset_active;
		(reset_active_i && act_any && !(grant_i && pend_any)) |=> !st.act[$past(act_idx)];
	endproperty
	a_reset_active: assert property (p_reset_active) else $error("reset-active missed top level");

	property p_group_enable;
		(bus_done && address_i == pic_pkg::A_SELECT && st.panel && st.opcode == pic_pkg::OP_GRP_ENABLE)
			|=> ((st.en & $past(sel_mask)) == $past(sel_mask));
	endproperty
	a_group_enable: assert property (p_group_enable) else $error("group enable failed");

	property p_group_keep;
		(bus_done && address_i == pic_pkg::A_SELECT && st.panel)
			|=> ((st.en & ~$past(sel_mask)) == ($past(st.en) & ~$past(sel_mask)));
	endproperty
	a_group_keep: assert property (p_group_keep) else $error("unselected enable changed");

	property p_special_top;
		(st.req[pic_pkg::LVL_PWR_FAIL] && !st.act[pic_pkg::LVL_PWR_FAIL]) |-> (irq_o && override_o && pend_idx == 7'h00);
	endproperty
	a_special_top: assert property (p_special_top) else $error("power-fail level not served first");
endmodule // pic_ctrl

// ---- tb/pic_cpu_model.sv ----
// processor timing and control model that strobes, grants and retires levels
`timescale 1ns/1ps
module pic_cpu_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic irq_i,
	input wire logic grant_en_i,
	input wire logic done_i,
	output logic req_strobe_o,
	output logic grant_o,
	output logic reset_active_o
);
	// ----------------------------------------------------------------
	// strobes: grant_en_i low models a slow processor that defers service
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			req_strobe_o <= 1'b0;
			grant_o <= 1'b0;
			reset_active_o <= 1'b0;
		end
		else
		begin
			// strobe every other cycle so a source really waits for its gate
			req_strobe_o <= ~req_strobe_o;
			grant_o <= irq_i & grant_en_i & ~grant_o;
			reset_active_o <= done_i & ~reset_active_o;
		end
	end
endmodule // pic_cpu_model

// ---- tb/testbench.sv ----
// self-checking bench for the priority interrupt controller
`timescale 1ns/1ps
module testbench;
	logic clk_i, rst_i, read_i, write_i, waitrequest_o, pwr_fail_i, irq_o, override_o, spb_valid_o, stall_i;
	logic req_strobe_i, grant_i, reset_active_i, grant_en, done;
	logic [7:0] address_i;
	logic [1:0] unit_std_i;
	logic [31:0] writedata_i, readdata_o;
	logic [95:0] irq_src_i;
	logic [15:0] spb_word_o;
	int n_errors = 0;
	int checked = 0;

	pic_ctrl pic_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
		.write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hF), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .pwr_fail_i(pwr_fail_i), .stall_i(stall_i), .irq_src_i(irq_src_i),
		.unit_std_i(unit_std_i), .req_strobe_i(req_strobe_i), .grant_i(grant_i), .reset_active_i(reset_active_i),
		.irq_o(irq_o), .override_o(override_o), .spb_word_o(spb_word_o), .spb_valid_o(spb_valid_o));
	pic_cpu_model pic_cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_o), .grant_en_i(grant_en),
		.done_i(done), .req_strobe_o(req_strobe_i), .grant_o(grant_i), .reset_active_o(reset_active_i));

	always #10 clk_i = ~clk_i;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// one Avalon access; request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		read_i <= ~w;
		write_i <= w;
		address_i <= a;
		writedata_i <= d;
		// no local limit: only the watchdog ends a hung access
		do
		begin
			@(posedge clk_i);
		end
		while (waitrequest_o !== 1'b0);
		q = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	function automatic logic [15:0] vw(input logic [15:0] p);
		return pic_pkg::SPB_TEMPLATE | ((pic_pkg::VEC_BASE + p) & pic_pkg::SPB_ADDR_MASK);
	endfunction

	// waits for the branch word pulse; a missing pulse shows in the top half
	task automatic gnt(input logic [15:0] exp);
		int n;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (spb_valid_o !== 1'b1 && n < 100);
		chk({15'h0, spb_valid_o, spb_word_o}, {16'h1, exp});
	endtask

	task automatic fin;
		done <= 1'b1;
		@(posedge clk_i);
		done <= 1'b0;
		cyc(3);
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		address_i = 8'h00;
		read_i = 1'b0;
		write_i = 1'b0;
		writedata_i = 32'h0;
		pwr_fail_i = 1'b0;
		stall_i = 1'b0;
		unit_std_i = 2'h0;
		irq_src_i = 96'h0;
		grant_en = 1'b0;
		done = 1'b0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdc(pic_pkg::A_CTRL, 32'h0);
		rdc(pic_pkg::A_ENABLE, 32'h0);
		rdc(pic_pkg::A_ACTIVE, 32'h0);
		rdc(8'hFC, 32'h0);
		chk({31'h0, irq_o}, 32'h0);
		$display("test reset done");
		wr(pic_pkg::A_CTRL, 32'h1);
		wr(pic_pkg::A_OPCODE, {16'h0, pic_pkg::OP_GRP_ENABLE});
		wr(pic_pkg::A_SELECT, 32'h201F);
		wr(pic_pkg::A_GROUP, 32'h2);
		rdc(pic_pkg::A_ENABLE, 32'h1F);
		wr(pic_pkg::A_OPCODE, {16'h0, pic_pkg::OP_GRP_DISABLE});
		wr(pic_pkg::A_SELECT, 32'h2018);
		rdc(pic_pkg::A_ENABLE, 32'h7);
		wr(pic_pkg::A_GROUP, 32'h0);
		rdc(pic_pkg::A_ENABLE, 32'h0);
		wr(pic_pkg::A_GROUP, 32'h2);
		$display("test enable done");
		irq_src_i <= 96'h1 << 27;
		cyc(6);
		chk({31'h0, irq_o}, 32'h0);
		irq_src_i <= (96'h1 << 24) | (96'h1 << 26);
		cyc(6);
		irq_src_i <= 96'h0;
		chk({31'h0, irq_o}, 32'h1);
		grant_en <= 1'b1;
		gnt(vw(16'd24));
		cyc(3);
		chk({31'h0, irq_o}, 32'h0);
		rdc(pic_pkg::A_ACTIVE, 32'h1);
		fin();
		gnt(vw(16'd26));
		rdc(pic_pkg::A_ACTIVE, 32'h4);
		irq_src_i <= 96'h1 << 24;
		cyc(4);
		irq_src_i <= 96'h0;
		gnt(vw(16'd24));
		rdc(pic_pkg::A_ACTIVE, 32'h5);
		fin();
		rdc(pic_pkg::A_ACTIVE, 32'h4);
		fin();
		rdc(pic_pkg::A_ACTIVE, 32'h0);
		rdc(pic_pkg::A_REQUEST, 32'h8);
		$display("test priority done");
		grant_en <= 1'b0;
		pwr_fail_i <= 1'b1;
		stall_i <= 1'b1;
		cyc(6);
		chk({30'h0, override_o, irq_o}, 32'h3);
		grant_en <= 1'b1;
		pwr_fail_i <= 1'b0;
		stall_i <= 1'b0;
		gnt(pic_pkg::SPB_TEMPLATE | pic_pkg::VEC_SPECIAL);
		fin();
		gnt(pic_pkg::SPB_TEMPLATE | (pic_pkg::VEC_SPECIAL + 16'h0001));
		fin();
		wr(pic_pkg::A_CTRL, 32'h0);
		rdc(pic_pkg::A_ENABLE, 32'h0);
		wr(pic_pkg::A_CONNECT, 32'h6000);
		rdc(pic_pkg::A_CONNECT, 32'h1);
		unit_std_i <= 2'h3;
		cyc(6);
		unit_std_i <= 2'h0;
		wr(pic_pkg::A_GROUP, 32'h0);
		rdc(pic_pkg::A_REQUEST, 32'h400);
		$display("test special done");
		give_verdict();
	end

	// bounds the run well beyond the few hundred cycles the tests need
	initial
	begin
		repeat (5000) @(posedge clk_i);
		n_errors++;
		give_verdict();
	end
endmodule // testbench
